/* slpc_defs.vh */
// Constants for the sleep and clock gating controller.
`ifndef SLPC_DEFS_VH
`define SLPC_DEFS_VH
// ==========================================================================
// Register word indices (printed offsets are not all multiples of four).
`define SLPC_IDX_SLEEP_MODE_CONTROL   8'h33
`define SLPC_IDX_CORE_MISC_CONTROL    8'h35
`define SLPC_IDX_PERIPH_CLOCK_GATE    8'h64
`define SLPC_IDX_SLEEP_CONTROL_CMD    8'h70
`define SLPC_IDX_SLEEP_STATUS         8'h71
`define SLPC_ADDR_BITS                10
// ==========================================================================
// Reset values.
`define SLPC_RST_SLEEP_MODE_CONTROL   8'h00
`define SLPC_RST_CORE_MISC_CONTROL    8'h00
`define SLPC_RST_PERIPH_CLOCK_GATE    8'h00
// ==========================================================================
// Field positions.
`define SLPC_SMC_ARM                  0
`define SLPC_SMC_MODE_LO              1
`define SLPC_SMC_MODE_HI              3
`define SLPC_SMC_MASK                 8'h0f
`define SLPC_MCU_VEC_UNLOCK           0
`define SLPC_MCU_VEC_SEL              1
`define SLPC_MCU_PULLUP_OFF           4
`define SLPC_MCU_BOD_UNLOCK           5
`define SLPC_MCU_BOD_OFF              6
`define SLPC_PCG_CONVERTER            0
`define SLPC_PCG_SERIAL_PORT_ZERO     1
`define SLPC_PCG_SERIAL_PERIPHERAL    2
`define SLPC_PCG_TIMER_ONE            3
`define SLPC_PCG_TIMER_ZERO           5
`define SLPC_PCG_TIMER_TWO            6
`define SLPC_PCG_TWO_WIRE_PORT        7
`define SLPC_PCG_MASK                 8'hef
// ==========================================================================
// Sleep mode codes.
`define SLPC_MODE_IDLE                3'h0
`define SLPC_MODE_NOISE_RED           3'h1
`define SLPC_MODE_POWER_DOWN          3'h2
`define SLPC_MODE_POWER_SAVE          3'h3
`define SLPC_MODE_STANDBY             3'h6
`define SLPC_MODE_EXT_STANDBY         3'h7
// ==========================================================================
// Timing counts in system clock cycles.
`define SLPC_BOD_UNLOCK_CYCLES        3'h4
`define SLPC_BOD_ACTIVE_CYCLES        3'h3
`define SLPC_STANDBY_WAKE_CYCLES      8'h06
`define SLPC_WAKE_HALT_CYCLES         8'h04
`endif

/* slpc_monitor.sv */
// Concurrent checks on the sleep and clock gating controller ports.
`timescale 1ns/1ps
`include "slpc_defs.vh"
module slpc_monitor (
  // Clock, reset and bus.
  input logic        clk_in,
  input logic        rst_n_in,
  input logic        wb_we_in,
  input logic [9:0]  wb_adr_in,
  input logic [3:0]  wb_sel_in,
  input logic [31:0] wb_dat_in,
  input logic        wb_ack_out,
  // Core status and sleep outputs.
  input logic        sleep_instr_in,
  input logic        crystal_clock_in,
  input logic        timer_two_async_select_in,
  input logic        watchdog_enable_in,
  input logic        core_halt_out,
  input logic        asleep_out,
  input logic [2:0]  active_mode_out,
  input logic        main_osc_run_out,
  input logic        io_clock_run_out,
  input logic        input_buffer_off_out,
  input logic        comparator_disable_out,
  input logic        watchdog_run_out,
  input logic [7:0]  periph_clock_run_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [7:0] smc;
  logic [7:0] pcg;
  // Shadow registers follow acked writes, so checks never read design internals.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      smc <= 8'h00;
      pcg <= 8'h00;
    end else if (wb_ack_out && wb_we_in && wb_sel_in[0]) begin
      if (wb_adr_in[9:2] == `SLPC_IDX_SLEEP_MODE_CONTROL) smc <= wb_dat_in[7:0] & `SLPC_SMC_MASK;
      if (wb_adr_in[9:2] == `SLPC_IDX_PERIPH_CLOCK_GATE) pcg <= wb_dat_in[7:0] & `SLPC_PCG_MASK;
    end
  end
  no_arm_sleep_a: assert property (sleep_instr_in && !core_halt_out && !smc[0] |-> ##2 !asleep_out)
    else $error("sleep taken with arm bit clear");
  reserved_code_a: assert property (sleep_instr_in && !core_halt_out && smc[3:2] == 2'b10 |-> ##2 !asleep_out)
    else $error("sleep taken on reserved code");
  standby_no_xtal_a: assert property (sleep_instr_in && !core_halt_out && smc[3:2] == 2'b11 && !crystal_clock_in
    |-> ##2 !asleep_out)
    else $error("standby taken without crystal");
  mode_entry_a: assert property (sleep_instr_in && !core_halt_out && smc[0] && !smc[3]
    |-> ##2 asleep_out && active_mode_out == smc[3:1])
    else $error("low sleep code not entered");
  standby_osc_a: assert property (sleep_instr_in && !core_halt_out && smc[0] && smc[3:2] == 2'b11 && crystal_clock_in
    |-> ##2 asleep_out && main_osc_run_out)
    else $error("standby entry without oscillator");
  standby_wake_a: assert property ($fell(asleep_out) && active_mode_out[2:1] == 2'b11
    |-> core_halt_out [*6] ##1 !core_halt_out)
    else $error("standby wake length wrong");
  gate_clock_a: assert property (!core_halt_out && !$past(core_halt_out) && !$past(core_halt_out, 2) && $stable(pcg)
    |-> (periph_clock_run_out & 8'haf) == (~pcg & 8'haf))
    else $error("peripheral clock does not follow gate bits");
  timer_two_a: assert property (!core_halt_out && !$past(core_halt_out) && !$past(core_halt_out, 2) && $stable(pcg)
    && $stable(timer_two_async_select_in)
    |-> periph_clock_run_out[6] == !(pcg[6] && !timer_two_async_select_in))
    else $error("timer two gating wrong");
  deep_buffers_a: assert property (asleep_out && active_mode_out[1] |-> input_buffer_off_out && !io_clock_run_out)
    else $error("input buffers live in deep sleep");
  comparator_off_a: assert property (asleep_out |-> comparator_disable_out == active_mode_out[1])
    else $error("comparator disable wrong in sleep");
  watchdog_run_a: assert property (asleep_out && watchdog_enable_in |-> watchdog_run_out)
    else $error("watchdog stopped in sleep");
  cover property (sleep_instr_in && smc[0] && !core_halt_out);
  cover property ($fell(asleep_out) && active_mode_out == 3'h6);
  cover property (asleep_out && active_mode_out == 3'h7);
endmodule
bind slpc_sleep_ctrl slpc_monitor u_mon (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
  .wb_dat_in(wb_dat_in), .wb_ack_out(wb_ack_out), .sleep_instr_in(sleep_instr_in),
  .crystal_clock_in(crystal_clock_in), .timer_two_async_select_in(timer_two_async_select_in),
  .watchdog_enable_in(watchdog_enable_in), .core_halt_out(core_halt_out), .asleep_out(asleep_out),
  .active_mode_out(active_mode_out), .main_osc_run_out(main_osc_run_out), .io_clock_run_out(io_clock_run_out),
  .input_buffer_off_out(input_buffer_off_out), .comparator_disable_out(comparator_disable_out),
  .watchdog_run_out(watchdog_run_out), .periph_clock_run_out(periph_clock_run_out)
);

/* slpc_periph_model.sv */
// Model of two gated peripherals that count on their own clocks.
`timescale 1ns/1ps
module slpc_periph_model (
  // Clock and reset.
  input  logic       clk_in,
  input  logic       rst_n_in,
  // Clock run enables from the controller.
  input  logic [7:0] run_in,
  // Peripheral state, frozen while gated.
  output logic [7:0] conv_count_out,
  output logic [7:0] timer_count_out
);
  // A counter moves only on its own clock, so gating must hold it exactly.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      conv_count_out <= 8'h00;
      timer_count_out <= 8'h00;
    end else begin
      if (run_in[0]) conv_count_out <= conv_count_out + 8'h01;
      if (run_in[6]) timer_count_out <= timer_count_out + 8'h01;
    end
  end
endmodule

/* slpc_sleep_ctrl.v */
// Sleep mode sequencing, brown-out sleep shutdown and peripheral clock gating.
// Function
// - Mode 110 with crystal clock enters Standby, oscillator kept running.
// - Standby wakes and resumes six cycles after the wake condition.
// - Mode 111 with crystal clock enters Extended Standby, six-cycle wake.
// - A set gate bit stops that peripheral clock and blocks its registers.
// - Clearing a gate bit restarts the clock with state kept.
// - Per-peripheral gating acts only in Active and Idle.
// - Input buffers off when I/O and converter clocks stop, except wake pins.
// - Mode field bits 3:1 decode idle, noise, down, save; 100/101 reserved.
// - Sleep instruction sleeps only when the arm bit is one.
// - Shutdown bit set only by unlock write then shutdown write within four cycles.
// - A validly set shutdown bit becomes active three cycles later.
// - Shutdown bit clears itself six cycles after being set.
// - Timer two gating applies only in synchronous mode.
// - Converter gated blocks comparator use of converter multiplexer.
// - An enabled converter stays enabled in sleep; restart forces extended conversion.
// - Comparator disabled automatically outside Idle and Noise Reduction sleep.
// - An enabled watchdog keeps running in every sleep mode.
// - Interrupt wake halts the core four cycles plus start-up time.
`timescale 1ns/1ps
`include "slpc_defs.vh"
module slpc_sleep_ctrl (
  // Clock and reset.
  input  wire        clk_in,
  input  wire        rst_n_in,
  // Wishbone classic slave.
  input  wire        wb_cyc_in,
  input  wire        wb_stb_in,
  input  wire        wb_we_in,
  input  wire [9:0]  wb_adr_in,
  input  wire [3:0]  wb_sel_in,
  input  wire [31:0] wb_dat_in,
  output reg  [31:0] wb_dat_out,
  output wire        wb_ack_out,
  // Core and system status, all on the system clock.
  input  wire        sleep_instr_in,
  input  wire        crystal_clock_in,
  input  wire        timer_two_async_select_in,
  input  wire        converter_enable_in,
  input  wire        watchdog_enable_in,
  input  wire [7:0]  wake_pin_need_in,
  // Wake request, from outside the clock domain.
  input  wire        wake_request_in,
  // Start-up time in cycles for every mode except the two standby modes.
  input  wire [7:0]  startup_cycles_in,
  // Sleep and clock outputs.
  output reg         core_halt_out,
  output reg         asleep_out,
  output reg  [2:0]  active_mode_out,
  output reg         io_clock_run_out,
  output reg         converter_clock_run_out,
  output reg         main_osc_run_out,
  output reg         brownout_off_out,
  output reg         input_buffer_off_out,
  output reg  [7:0]  input_buffer_enable_out,
  output reg         comparator_disable_out,
  output reg         comparator_mux_block_out,
  output reg         converter_keep_out,
  output reg         converter_extended_out,
  output reg         watchdog_run_out,
  output reg  [7:0]  periph_clock_run_out,
  output reg  [7:0]  periph_reg_block_out,
  output reg         pullup_global_disable_out,
  output reg         vector_table_select_out
);

  // ==========================================================================
  // State codes.
  // Code 3 is unused; the sequencer falls back to run if it is ever seen.
  localparam ST_RUN   = 2'd0;
  localparam ST_SLEEP = 2'd1;
  localparam ST_WAKE  = 2'd2;

  // ==========================================================================
  // Registers.
  // Software-visible registers first, then sequence counters and state.
  reg  [7:0] sleep_mode_control;
  reg  [7:0] core_misc_control;
  reg  [7:0] peripheral_clock_gate;
  reg        ack;
  reg  [2:0] unlock_cnt;
  reg  [2:0] bod_cnt;
  reg        bod_pending;
  reg        bod_active;
  reg        bod_sleep;
  reg  [1:0] state;
  reg  [2:0] mode;
  reg  [7:0] wake_cnt;
  reg        wake_sync1;
  reg        wake_sync2;
  reg        vec_unlock_armed;
  reg        conv_was_on;

  // Bus decode. The word index ignores the byte lanes, so neighbouring
  // offsets sit four bytes apart in the byte address space.
  wire       req = wb_cyc_in & wb_stb_in;
  wire       wr  = req & wb_we_in & wb_sel_in[0] & ~ack;
  wire [7:0] byte_addr = wb_adr_in[9:2];
  wire       hit_smc = (byte_addr == `SLPC_IDX_SLEEP_MODE_CONTROL);
  wire       hit_mcu = (byte_addr == `SLPC_IDX_CORE_MISC_CONTROL);
  wire       hit_pcg = (byte_addr == `SLPC_IDX_PERIPH_CLOCK_GATE);
  wire       hit_sts = (byte_addr == `SLPC_IDX_SLEEP_STATUS);
  // Mode field and the two data bits of the brown-out timed sequence.
  wire [2:0] sel_mode = sleep_mode_control[`SLPC_SMC_MODE_HI:`SLPC_SMC_MODE_LO];
  wire       mcu_off_bit = wb_dat_in[`SLPC_MCU_BOD_OFF];
  wire       mcu_unl_bit = wb_dat_in[`SLPC_MCU_BOD_UNLOCK];

  // Ack is a registered pulse of one cycle.
  assign wb_ack_out = ack;

  // ==========================================================================
  // Mode decode: flags whether the selected code may be entered at all.
  // Standby codes need the crystal, because without it the oscillator that
  // makes the short wake possible is not there to keep running.
  reg        mode_valid;
  always @* begin
    case (sel_mode)
      `SLPC_MODE_IDLE,
      `SLPC_MODE_NOISE_RED,
      `SLPC_MODE_POWER_DOWN,
      `SLPC_MODE_POWER_SAVE:  mode_valid = 1'b1;
      `SLPC_MODE_STANDBY:     mode_valid = crystal_clock_in;
      `SLPC_MODE_EXT_STANDBY: mode_valid = crystal_clock_in;
      default:                mode_valid = 1'b0;
    endcase
  end

  // ==========================================================================
  // Bus slave: answers one cycle after the request, unmapped reads as zero.
  // A write lands on the edge that raises ack; the ack-high cycle never makes
  // a second write because wr is masked by ack. Read data is registered with
  // ack, so it stands for the whole cycle in which the master samples it.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      ack <= req & ~ack;
      if (req & ~ack) begin
        if (hit_smc) begin
          wb_dat_out <= {24'h00_0000, sleep_mode_control};
        end else if (hit_mcu) begin
          wb_dat_out <= {24'h00_0000, core_misc_control};
        end else if (hit_pcg) begin
          wb_dat_out <= {24'h00_0000, peripheral_clock_gate};
        end else if (hit_sts) begin
          // Status: entered mode, live and pending shutdown, sequencer state.
          wb_dat_out <= {24'h00_0000, 1'b0, mode, bod_active, bod_pending, state};
        end else begin
          wb_dat_out <= 32'h0000_0000;
        end
      end
    end
  end

  // ==========================================================================
  // Control registers and the brown-out shutdown timed sequence.
  // The self-clear counter wins over software: shutdown cannot be held on.
  // One down counter serves both phases: pending until the bit is live, then
  // live until it clears itself. A set write is refused while either phase
  // runs, so a second sequence cannot stretch the live window.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sleep_mode_control <= `SLPC_RST_SLEEP_MODE_CONTROL;
      core_misc_control <= `SLPC_RST_CORE_MISC_CONTROL;
      peripheral_clock_gate <= `SLPC_RST_PERIPH_CLOCK_GATE;
      unlock_cnt <= 3'h0;
      bod_cnt <= 3'h0;
      bod_pending <= 1'b0;
      bod_active <= 1'b0;
      vec_unlock_armed <= 1'b0;
    end else begin
      // The unlock window closes by itself four cycles after the unlock write.
      if (unlock_cnt != 3'h0) begin
        unlock_cnt <= unlock_cnt - 3'h1;
      end
      if (bod_pending) begin
        if (bod_cnt == 3'h1) begin
          bod_pending <= 1'b0;
          bod_active <= 1'b1;
          bod_cnt <= `SLPC_BOD_ACTIVE_CYCLES;
        end else begin
          bod_cnt <= bod_cnt - 3'h1;
        end
      end else if (bod_active) begin
        if (bod_cnt == 3'h1) begin
          bod_active <= 1'b0;
          core_misc_control[`SLPC_MCU_BOD_OFF] <= 1'b0;
          bod_cnt <= 3'h0;
        end else begin
          bod_cnt <= bod_cnt - 3'h1;
        end
      end
      if (wr & hit_smc) begin
        sleep_mode_control <= wb_dat_in[7:0] & `SLPC_SMC_MASK;
      end
      if (wr & hit_pcg) begin
        peripheral_clock_gate <= wb_dat_in[7:0] & `SLPC_PCG_MASK;
      end
      // Only the pull-up and the two unlock bits take software data directly.
      if (wr & hit_mcu) begin
        core_misc_control[`SLPC_MCU_PULLUP_OFF] <= wb_dat_in[`SLPC_MCU_PULLUP_OFF];
        core_misc_control[`SLPC_MCU_BOD_UNLOCK] <= mcu_unl_bit;
        core_misc_control[`SLPC_MCU_VEC_UNLOCK] <= wb_dat_in[`SLPC_MCU_VEC_UNLOCK];
        vec_unlock_armed <= wb_dat_in[`SLPC_MCU_VEC_UNLOCK];
        if (vec_unlock_armed & ~wb_dat_in[`SLPC_MCU_VEC_UNLOCK]) begin
          core_misc_control[`SLPC_MCU_VEC_SEL] <= wb_dat_in[`SLPC_MCU_VEC_SEL];
        end
        if (mcu_off_bit & mcu_unl_bit) begin
          unlock_cnt <= `SLPC_BOD_UNLOCK_CYCLES;
        end else if (mcu_off_bit & ~mcu_unl_bit & (unlock_cnt != 3'h0) & ~bod_pending & ~bod_active) begin
          core_misc_control[`SLPC_MCU_BOD_OFF] <= 1'b1;
          unlock_cnt <= 3'h0;
          bod_pending <= 1'b1;
          bod_cnt <= `SLPC_BOD_ACTIVE_CYCLES;
        end
      end
      // The vector unlock stays armed until the next write to this register,
      // which either spends it or replaces it. It has no timer of its own.
    end
  end

  // ==========================================================================
  // Wake request synchroniser. Only the second stage is read, so a wake edge
  // close to the clock edge costs at most one extra cycle of sleep.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wake_sync1 <= 1'b0;
      wake_sync2 <= 1'b0;
    end else begin
      wake_sync1 <= wake_request_in;
      wake_sync2 <= wake_sync1;
    end
  end

  // Non-standby halt length; a large start-up value saturates instead of
  // wrapping round to a short halt.
  wire [8:0] wake_sum_raw = {1'b0, `SLPC_WAKE_HALT_CYCLES} + {1'b0, startup_cycles_in};
  wire [7:0] wake_sum     = wake_sum_raw[8] ? 8'hff : wake_sum_raw[7:0];

  // ==========================================================================
  // Sleep sequencer. Standby modes wake in a fixed count, all other modes
  // (idle and noise included) add the start-up time to the core halt.
  // The sleep instruction is only looked at in run, so a second pulse during
  // the wake count cannot re-enter sleep before the core is released.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ST_RUN;
      mode <= `SLPC_MODE_IDLE;
      wake_cnt <= 8'h00;
      bod_sleep <= 1'b0;
    end else begin
      case (state)
        ST_RUN: begin
          if (sleep_instr_in & sleep_mode_control[`SLPC_SMC_ARM] & mode_valid) begin
            state <= ST_SLEEP;
            mode <= sel_mode;
            bod_sleep <= bod_active;
          end
        end
        ST_SLEEP: begin
          if (wake_sync2) begin
            state <= ST_WAKE;
            bod_sleep <= 1'b0;
            if ((mode == `SLPC_MODE_STANDBY) | (mode == `SLPC_MODE_EXT_STANDBY)) begin
              wake_cnt <= `SLPC_STANDBY_WAKE_CYCLES;
            end else begin
              wake_cnt <= wake_sum;
            end
          end
        end
        ST_WAKE: begin
          // The count includes the cycle that leaves for run.
          if (wake_cnt <= 8'h01) begin
            state <= ST_RUN;
            wake_cnt <= 8'h00;
          end else begin
            wake_cnt <= wake_cnt - 8'h01;
          end
        end
        default: begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  // ==========================================================================
  // Converter restart tracking for extended conversion.
  // The flag stays high while the converter is off and for the first cycle
  // back on; the converter is expected to latch it at its next start.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      conv_was_on <= 1'b0;
      converter_extended_out <= 1'b1;
    end else begin
      conv_was_on <= converter_enable_in;
      if (converter_enable_in & ~conv_was_on) begin
        converter_extended_out <= 1'b1;
      end else if (~converter_enable_in) begin
        converter_extended_out <= 1'b1;
      end else begin
        converter_extended_out <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Registered clock and power outputs.
  // light: core clocks of active and idle; noise: only the converter clock
  // survives. Everything below is registered so that the clock gates see
  // no decode glitches.
  wire sleeping = (state != ST_RUN);
  wire light = ~sleeping | (mode == `SLPC_MODE_IDLE);
  wire noise = sleeping & (mode == `SLPC_MODE_NOISE_RED);
  wire osc = ~sleeping | (mode == `SLPC_MODE_IDLE) | noise |
             (mode == `SLPC_MODE_STANDBY) | (mode == `SLPC_MODE_EXT_STANDBY);
  // Effective gate bits; timer two ignores its bit while it runs on its own clock.
  reg  [7:0] gate_eff;
  always @* begin
    gate_eff = peripheral_clock_gate;
    gate_eff[`SLPC_PCG_TIMER_TWO] = peripheral_clock_gate[`SLPC_PCG_TIMER_TWO] &
                                    ~timer_two_async_select_in;
  end

  // Output registers; reset leaves every clock running, the watchdog run output low and nothing gated.

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      core_halt_out <= 1'b0;
      asleep_out <= 1'b0;
      active_mode_out <= 3'h0;
      io_clock_run_out <= 1'b1;
      converter_clock_run_out <= 1'b1;
      main_osc_run_out <= 1'b1;
      brownout_off_out <= 1'b0;
      input_buffer_off_out <= 1'b0;
      input_buffer_enable_out <= 8'hff;
      comparator_disable_out <= 1'b0;
      comparator_mux_block_out <= 1'b0;
      converter_keep_out <= 1'b0;
      watchdog_run_out <= 1'b0;
      periph_clock_run_out <= 8'hff;
      periph_reg_block_out <= 8'h00;
      pullup_global_disable_out <= 1'b0;
      vector_table_select_out <= 1'b0;
    end else begin
      core_halt_out <= sleeping;
      asleep_out <= (state == ST_SLEEP);
      active_mode_out <= mode;
      io_clock_run_out <= light;
      converter_clock_run_out <= light | noise;
      main_osc_run_out <= osc;
      brownout_off_out <= bod_sleep & (state == ST_SLEEP);
      input_buffer_off_out <= ~(light | noise);
      input_buffer_enable_out <= (light | noise) ? 8'hff : wake_pin_need_in;
      comparator_disable_out <= sleeping & ~light & ~noise;
      comparator_mux_block_out <= peripheral_clock_gate[`SLPC_PCG_CONVERTER];
      converter_keep_out <= converter_enable_in;
      watchdog_run_out <= watchdog_enable_in;
      periph_clock_run_out <= light ? ~gate_eff : 8'h00;
      periph_reg_block_out <= gate_eff;
      pullup_global_disable_out <= core_misc_control[`SLPC_MCU_PULLUP_OFF];
      vector_table_select_out <= core_misc_control[`SLPC_MCU_VEC_SEL];
    end
  end

endmodule

/* tb_top.sv */
// Self-checking testbench for the sleep and clock gating controller.
`timescale 1ns/1ps
module tb_top;
  // Drivers and observed signals.
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, slp_in = 1'b0, xtal = 1'b1, async = 1'b0, wake = 1'b0;
  logic [9:0]  adr = 10'h000;
  logic [31:0] wdat = 32'h0000_0000, q;
  logic [31:0] rdat;
  logic        ack, halt, asleep, bod_off, mux, keep;
  logic        conv = 1'b0;
  logic [7:0]  run, ccnt, tcnt, snap, tsnap, blk, ibe;
  logic [7:0]  ia [3] = '{8'h33, 8'h64, 8'h70};
  logic [7:0]  em [3] = '{8'h0f, 8'hef, 8'h00};
  int          bad_count = 0, total_checks = 0, cycles = 0;
  always #4 clk_in = ~clk_in;
  slpc_sleep_ctrl DUT (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(4'hf), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .sleep_instr_in(slp_in),
    .crystal_clock_in(xtal), .timer_two_async_select_in(async), .converter_enable_in(conv),
    .watchdog_enable_in(1'b1), .wake_pin_need_in(8'h0f), .wake_request_in(wake), .startup_cycles_in(8'h02),
    .core_halt_out(halt), .asleep_out(asleep), .active_mode_out(), .io_clock_run_out(),
    .converter_clock_run_out(), .main_osc_run_out(), .brownout_off_out(bod_off), .input_buffer_off_out(),
    .input_buffer_enable_out(ibe), .comparator_disable_out(), .comparator_mux_block_out(mux),
    .converter_keep_out(keep),
    .converter_extended_out(), .watchdog_run_out(), .periph_clock_run_out(run), .periph_reg_block_out(blk),
    .pullup_global_disable_out(), .vector_table_select_out()
  );
  slpc_periph_model u_periph (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .run_in(run), .conv_count_out(ccnt), .timer_count_out(tcnt)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One classic cycle; the request holds until ack is sampled, then drops.
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h00_0000, d};
    @(posedge clk_in);
    while (ack !== 1'b1) @(posedge clk_in);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Sleep pulse; outputs follow the sequencer state one edge later, so entry
  // is judged two edges after the pulse. On entry, wake the core and wait.
  task automatic sleep_op(input logic e, input logic b, input logic [7:0] bx);
    @(posedge clk_in);
    slp_in <= 1'b1;
    @(posedge clk_in);
    slp_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk(asleep, e, "sleep entry");
    chk(halt, e, "core halt");
    if (e) begin
      chk(bod_off, b, "brown-out off");
      chk(ibe, bx, "input buffer enables");
      wake <= 1'b1;
      @(posedge clk_in);
      while (halt !== 1'b0) @(posedge clk_in);
      wake <= 1'b0;
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Cycle ceiling well above the few hundred cycles the sequence needs.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      bus(0, ia[i], 8'h00);
      chk(q, 32'h0000_0000, "reset value");
      bus(1, ia[i], 8'hff);
      bus(0, ia[i], 8'h00);
      chk(q, {24'h00_0000, em[i]}, "masked readback");
    end
    repeat (3) @(posedge clk_in);
    chk(run & 8'hef, 8'h00, "all gated");
    chk(blk, 8'hef, "registers blocked");
    chk(mux, 1'b1, "comparator mux blocked");
    snap = ccnt;
    tsnap = tcnt;
    repeat (5) @(posedge clk_in);
    chk(ccnt, snap, "state frozen");
    async <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk(run[6], 1'b1, "async timer two runs");
    chk(tcnt - tsnap, 32'h0000_0001, "async timer counts");
    async <= 1'b0;
    bus(1, 8'h64, 8'h00);
    conv <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk(run & 8'hef, 8'hef, "clocks restart");
    chk(ccnt - snap, 32'h0000_0002, "state resumes");
    chk(keep, 1'b1, "converter kept on");
    for (int m = 0; m < 8; m++) begin
      bus(1, 8'h33, {4'h0, 3'(m), 1'b1});
      sleep_op(m < 4 || m > 5, 1'b0, m[1] ? 8'h0f : 8'hff);
      bus(1, 8'h33, 8'h00);
    end
    xtal <= 1'b0;
    bus(1, 8'h33, 8'h0d);
    sleep_op(0, 0, 8'hff);
    xtal <= 1'b1;
    bus(1, 8'h33, 8'h04);
    sleep_op(0, 0, 8'hff);
    bus(1, 8'h33, 8'h05);
    bus(1, 8'h35, 8'h60);
    bus(1, 8'h35, 8'h40);
    repeat (2) @(posedge clk_in);
    sleep_op(1, 1, 8'h0f);
    bus(0, 8'h35, 8'h00);
    chk(q & 32'h0000_0040, 32'h0000_0000, "shutdown self clear");
    bus(1, 8'h35, 8'h60);
    repeat (6) @(posedge clk_in);
    bus(1, 8'h35, 8'h40);
    repeat (2) @(posedge clk_in);
    sleep_op(1, 0, 8'h0f);
    end_of_test();
  end
endmodule
